// >>> logic/rsg_pkg.sv
/*
 Constants, field layout and state type for the rail sequencing and group event block.
 Assumes a synchronous single clock design; users reference items as rsg_pkg::name.
*/
package rsg_pkg;
	localparam logic [7:0] RSG_CMD_ORDER = 8'hE0;
	localparam logic [7:0] RSG_CMD_GROUP = 8'hE2;
	localparam logic [7:0] RSG_CMD_IDENT = 8'hE4;
	localparam logic [4:0] RSG_LEN_ORDER = 5'h02;
	localparam logic [4:0] RSG_LEN_GROUP = 5'h04;
	localparam logic [4:0] RSG_LEN_IDENT = 5'h10;
	localparam logic [4:0] RSG_LEN_NONE = 5'h00;
	localparam logic [15:0] RSG_ORDER_MASK = 16'h9F9F;
	localparam logic [31:0] RSG_GROUP_MASK = 32'h003F3F3F;
	localparam int RSG_ID_W = 5;
	localparam int RSG_PRE_EN_BIT = 15;
	localparam int RSG_PRE_ID_LSB = 8;
	localparam int RSG_FOL_EN_BIT = 7;
	localparam int RSG_FOL_ID_LSB = 0;
	localparam int RSG_VOUT_EN_BIT = 21;
	localparam int RSG_VOUT_ID_LSB = 16;
	localparam int RSG_OPER_EN_BIT = 13;
	localparam int RSG_OPER_ID_LSB = 8;
	localparam int RSG_FAIL_MODE_BIT = 5;
	localparam int RSG_FAIL_ID_LSB = 0;
	localparam int RSG_EV_DATA_W = 16;
	localparam int RSG_OPER_W = 8;
	localparam logic [2:0] RSG_EV_POWER_GOOD = 3'h1;
	localparam logic [2:0] RSG_EV_POWER_DOWN = 3'h2;
	localparam logic [2:0] RSG_EV_VOUT = 3'h3;
	localparam logic [2:0] RSG_EV_OPERATION = 3'h4;
	localparam logic [2:0] RSG_EV_POWER_FAIL = 3'h5;
	typedef enum logic [1:0] {
		RSG_ST_OFF,
		RSG_ST_WAIT_PRE,
		RSG_ST_ON,
		RSG_ST_OFF_DELAY
	} rsg_state_type;
endpackage

// >>> logic/rsg_rail_seq.sv
/*
 Rail on/off state machine with turn-off delay and shutdown lockout.
 Assumes decoded event pulses arrive synchronous to clk, one cycle each.
*/
`timescale 1ns/10ps
module rsg_rail_seq #(
	parameter int DELAY_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	rsg_seq_if.seq sq
);
	rsg_pkg::rsg_state_type state;
	rsg_pkg::rsg_state_type next_state;
	logic [DELAY_W-1:0] cnt;
	logic [DELAY_W-1:0] next_cnt;
	logic lock;
	logic next_lock;
	logic on_q;
	logic next_on;
	logic wait_q;
	logic next_wait;

	assign sq.rail_on = on_q;
	assign sq.waiting = wait_q;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_lock = lock;
		next_on = on_q;
		// Lockout holds the rail off until the enable request is recycled
		if (!sq.en_req) begin
			next_lock = 1'b0;
		end
		if (sq.fail_seq || sq.fail_imm) begin
			next_lock = 1'b1;
		end
		case (state)
			rsg_pkg::RSG_ST_OFF: begin
				if (sq.en_req && !lock && !sq.fail_seq && !sq.fail_imm) begin
					next_state = rsg_pkg::RSG_ST_WAIT_PRE;
				end
			end
			rsg_pkg::RSG_ST_WAIT_PRE: begin
				if (!sq.en_req || lock || sq.fail_seq || sq.fail_imm) begin
					next_state = rsg_pkg::RSG_ST_OFF;
				end else if (sq.pre_ok) begin
					next_state = rsg_pkg::RSG_ST_ON;
					next_on = 1'b1;
				end
			end
			rsg_pkg::RSG_ST_ON: begin
				if (sq.fail_imm) begin
					next_state = rsg_pkg::RSG_ST_OFF;
					next_on = 1'b0;
				end else if (!sq.en_req || sq.follow_down || sq.fail_seq) begin
					next_state = rsg_pkg::RSG_ST_OFF_DELAY;
					next_cnt = sq.delay_val;
					if (sq.follow_down) begin
						next_lock = 1'b1;
					end
				end
			end
			rsg_pkg::RSG_ST_OFF_DELAY: begin
				if (sq.fail_imm || cnt == '0) begin
					next_state = rsg_pkg::RSG_ST_OFF;
					next_on = 1'b0;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			default: begin
				next_state = rsg_pkg::RSG_ST_OFF;
				next_on = 1'b0;
			end
		endcase
		next_wait = (next_state == rsg_pkg::RSG_ST_WAIT_PRE);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= rsg_pkg::RSG_ST_OFF;
			cnt <= '0;
			lock <= 1'b0;
			on_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			lock <= next_lock;
			on_q <= next_on;
			wait_q <= next_wait;
		end
	end
endmodule

// >>> logic/rsg_rail_sequencer.sv
/*
 Top of the rail sequencing and group event block: command register file,
 event bus decode, broadcast responses and the rail state machine.
 Assumes command and event inputs are synchronous to clk and each lasts one cycle.
*/
`timescale 1ns/10ps
module rsg_rail_sequencer #(
	parameter int DELAY_W = 16,
	parameter logic [15:0] ORDER_RESET = 16'h0000,
	parameter logic [31:0] GROUP_RESET = 32'h00000000,
	// Arbitrary identifier text, byte 0 in the low bits
	parameter logic [127:0] IDENT_VALUE = 128'h3130305F3044495F5145535F4C494152
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [4:0] cmd_count,
	input wire logic [31:0] cmd_wdata,
	output logic rsp_valid,
	output logic rsp_ok,
	output logic [4:0] rsp_count,
	output logic [127:0] rsp_data,
	input wire logic enable_request,
	input wire logic current_share_setup,
	input wire logic [DELAY_W-1:0] off_delay,
	input wire logic ev_valid,
	input wire logic [2:0] ev_kind,
	input wire logic [4:0] ev_source,
	input wire logic [4:0] ev_group,
	input wire logic ev_share,
	input wire logic [15:0] ev_data,
	output logic rail_on,
	output logic rail_waiting,
	output logic preceding_seen,
	output logic vout_update,
	output logic [15:0] vout_value,
	output logic oper_update,
	output logic [7:0] oper_value,
	output logic fail_taken
);
	rsg_seq_if #(.DELAY_W(DELAY_W)) sq ();

	logic [15:0] rail_order_config;
	logic [15:0] next_order;
	logic [31:0] rail_group_config;
	logic [31:0] next_group;
	logic next_rsp_valid;
	logic next_rsp_ok;
	logic [4:0] next_rsp_count;
	logic [127:0] next_rsp_data;
	logic pre_good;
	logic next_pre_good;
	logic next_vout_update;
	logic [15:0] next_vout_value;
	logic next_oper_update;
	logic [7:0] next_oper_value;
	logic next_fail_taken;
	logic pre_en;
	logic fol_en;
	logic [4:0] preceding_rail_number;
	logic [4:0] following_rail_number;
	logic fail_group_hit;
	logic fail_share_hit;
	logic fail_any;
	logic ev_good_pre;
	logic ev_down_pre;
	logic ev_fail;
	logic ev_vout_hit;
	logic ev_oper_hit;
	logic wr_order;
	logic wr_group;

	// Five-bit field at a given position of a 32-bit word
	function automatic logic [4:0] field5(input logic [31:0] word, input int lsb);
		logic [31:0] shifted;
		shifted = word >> lsb;
		return shifted[4:0];
	endfunction

	// Enabled identifier comparison used by every event filter except the current-share power-fail match
	function automatic logic id_hit(input logic en, input logic [4:0] own, input logic [4:0] seen);
		return en && (own == seen);
	endfunction

	function automatic logic ev_is(input logic valid, input logic [2:0] kind, input logic [2:0] want);
		return valid && (kind == want);
	endfunction

	// Write accepted only with the exact byte count of its command
	function automatic logic wr_hit(input logic [7:0] code, input logic [4:0] count,
		input logic [7:0] want, input logic [4:0] len);
		return (code == want) && (count == len);
	endfunction

	assign pre_en = rail_order_config[rsg_pkg::RSG_PRE_EN_BIT];
	assign fol_en = rail_order_config[rsg_pkg::RSG_FOL_EN_BIT];
	assign preceding_rail_number = field5({16'h0000, rail_order_config}, rsg_pkg::RSG_PRE_ID_LSB);
	assign following_rail_number = field5({16'h0000, rail_order_config}, rsg_pkg::RSG_FOL_ID_LSB);

	// Event and write decode shared by the trackers below
	assign ev_good_pre = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_POWER_GOOD) &&
		id_hit(1'b1, preceding_rail_number, ev_source);
	assign ev_down_pre = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_POWER_DOWN) &&
		id_hit(1'b1, preceding_rail_number, ev_source);
	assign ev_fail = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_POWER_FAIL);
	assign ev_vout_hit = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_VOUT) &&
		id_hit(rail_group_config[rsg_pkg::RSG_VOUT_EN_BIT],
		field5(rail_group_config, rsg_pkg::RSG_VOUT_ID_LSB), ev_group);
	assign ev_oper_hit = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_OPERATION) &&
		id_hit(rail_group_config[rsg_pkg::RSG_OPER_EN_BIT],
		field5(rail_group_config, rsg_pkg::RSG_OPER_ID_LSB), ev_group);
	assign wr_order = cmd_valid && cmd_write &&
		wr_hit(cmd_code, cmd_count, rsg_pkg::RSG_CMD_ORDER, rsg_pkg::RSG_LEN_ORDER);
	assign wr_group = cmd_valid && cmd_write &&
		wr_hit(cmd_code, cmd_count, rsg_pkg::RSG_CMD_GROUP, rsg_pkg::RSG_LEN_GROUP);

	// Order word; a refused write leaves it untouched
	always_comb begin
		next_order = rail_order_config;
		if (wr_order) begin
			next_order = cmd_wdata[15:0] & rsg_pkg::RSG_ORDER_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rail_order_config <= ORDER_RESET & rsg_pkg::RSG_ORDER_MASK;
		end else begin
			rail_order_config <= next_order;
		end
	end

	// Group block
	always_comb begin
		next_group = rail_group_config;
		if (wr_group) begin
			next_group = cmd_wdata & rsg_pkg::RSG_GROUP_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rail_group_config <= GROUP_RESET & rsg_pkg::RSG_GROUP_MASK;
		end else begin
			rail_group_config <= next_group;
		end
	end

	// Command answers; wrong length or identifier write is refused
	always_comb begin
		next_rsp_valid = cmd_valid;
		next_rsp_ok = 1'b0;
		next_rsp_count = rsg_pkg::RSG_LEN_NONE;
		next_rsp_data = '0;
		if (cmd_valid) begin
			case (cmd_code)
				rsg_pkg::RSG_CMD_ORDER: begin
					if (!cmd_write) begin
						next_rsp_ok = 1'b1;
						next_rsp_count = rsg_pkg::RSG_LEN_ORDER;
						next_rsp_data = {112'h0, rail_order_config};
					end else if (cmd_count == rsg_pkg::RSG_LEN_ORDER) begin
						next_rsp_ok = 1'b1;
						next_rsp_count = rsg_pkg::RSG_LEN_ORDER;
					end
				end
				rsg_pkg::RSG_CMD_GROUP: begin
					if (!cmd_write) begin
						next_rsp_ok = 1'b1;
						next_rsp_count = rsg_pkg::RSG_LEN_GROUP;
						next_rsp_data = {96'h0, rail_group_config};
					end else if (cmd_count == rsg_pkg::RSG_LEN_GROUP) begin
						next_rsp_ok = 1'b1;
						next_rsp_count = rsg_pkg::RSG_LEN_GROUP;
					end
				end
				rsg_pkg::RSG_CMD_IDENT: begin
					// Read-only: a write is refused and stores nothing
					if (!cmd_write) begin
						next_rsp_ok = 1'b1;
						next_rsp_count = rsg_pkg::RSG_LEN_IDENT;
						next_rsp_data = IDENT_VALUE;
					end
				end
				default: begin
					next_rsp_ok = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsp_valid <= 1'b0;
			rsp_ok <= 1'b0;
			rsp_count <= rsg_pkg::RSG_LEN_NONE;
			rsp_data <= '0;
		end else begin
			rsp_valid <= next_rsp_valid;
			rsp_ok <= next_rsp_ok;
			rsp_count <= next_rsp_count;
			rsp_data <= next_rsp_data;
		end
	end

	// Preceding rail power-good tracking
	always_comb begin
		next_pre_good = pre_good;
		if (ev_down_pre) begin
			next_pre_good = 1'b0;
		end
		if (ev_good_pre) begin
			next_pre_good = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_good <= 1'b0;
		end else begin
			pre_good <= next_pre_good;
		end
	end

	// Power-fail matching by own group, or by current-share membership
	assign fail_group_hit = ev_fail &&
		id_hit(1'b1, field5(rail_group_config, rsg_pkg::RSG_FAIL_ID_LSB), ev_group);
	assign fail_share_hit = ev_fail && current_share_setup && ev_share;
	assign fail_any = fail_group_hit || fail_share_hit;

	// Shared phases must drop together, so a share hit always stops at once
	assign sq.en_req = enable_request;
	assign sq.pre_ok = !pre_en || pre_good;
	assign sq.follow_down = ev_is(ev_valid, ev_kind, rsg_pkg::RSG_EV_POWER_DOWN) &&
		id_hit(fol_en, following_rail_number, ev_source);
	assign sq.fail_imm = fail_share_hit ||
		(fail_group_hit && rail_group_config[rsg_pkg::RSG_FAIL_MODE_BIT]);
	assign sq.fail_seq = fail_group_hit && !fail_share_hit &&
		!rail_group_config[rsg_pkg::RSG_FAIL_MODE_BIT];
	assign sq.delay_val = off_delay;

	// Broadcast output-voltage events; the value holds until the next match
	always_comb begin
		next_vout_update = ev_vout_hit;
		next_vout_value = vout_value;
		if (ev_vout_hit) begin
			next_vout_value = ev_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vout_update <= 1'b0;
			vout_value <= '0;
		end else begin
			vout_update <= next_vout_update;
			vout_value <= next_vout_value;
		end
	end

	// Broadcast operation events; only the low byte is meaningful
	always_comb begin
		next_oper_update = ev_oper_hit;
		next_oper_value = oper_value;
		if (ev_oper_hit) begin
			next_oper_value = ev_data[rsg_pkg::RSG_OPER_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oper_update <= 1'b0;
			oper_value <= '0;
		end else begin
			oper_update <= next_oper_update;
			oper_value <= next_oper_value;
		end
	end

	// Power-fail acknowledge, one pulse per matching event
	always_comb begin
		next_fail_taken = fail_any;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fail_taken <= 1'b0;
		end else begin
			fail_taken <= next_fail_taken;
		end
	end

	assign rail_on = sq.rail_on;
	assign rail_waiting = sq.waiting;
	assign preceding_seen = pre_good;

	rsg_rail_seq #(
		.DELAY_W(DELAY_W)
	) u_seq (
		.clk(clk),
		.sys_rst(sys_rst),
		.sq(sq)
	);
endmodule

// >>> logic/rsg_seq_if.sv
/*
 Carrier between the command and event front end and the rail state machine.
 Assumes both ends share clk and sys_rst.
*/
`timescale 1ns/10ps
interface rsg_seq_if #(
	parameter int DELAY_W = 16
);
	logic en_req;
	logic pre_ok;
	logic follow_down;
	logic fail_seq;
	logic fail_imm;
	logic [DELAY_W-1:0] delay_val;
	logic rail_on;
	logic waiting;
	modport ctrl (
		output en_req, pre_ok, follow_down, fail_seq, fail_imm, delay_val,
		input rail_on, waiting
	);
	modport seq (
		input en_req, pre_ok, follow_down, fail_seq, fail_imm, delay_val,
		output rail_on, waiting
	);
endinterface

// >>> verification/rsg_peer_model.sv
/*
 Peer rail model on the event bus: one event per send call.
 Assumes a single calling process, after reset release.
*/
`timescale 1ns/10ps
module rsg_peer_model (
	input wire logic clk,
	output logic ev_valid,
	output logic [2:0] ev_kind,
	output logic [4:0] ev_source,
	output logic [4:0] ev_group,
	output logic ev_share,
	output logic [15:0] ev_data
);
	initial begin
		ev_valid = 1'h0;
		ev_kind = 3'h0;
		ev_source = 5'h0;
		ev_group = 5'h0;
		ev_share = 1'h0;
		ev_data = 16'h0;
	end
	task send(input logic [2:0] k, input logic [4:0] src, input logic [4:0] grp, input logic sh, input logic [15:0] d);
		@(posedge clk);
		ev_valid <= 1'h1;
		ev_kind <= k;
		ev_source <= src;
		ev_group <= grp;
		ev_share <= sh;
		ev_data <= d;
		@(posedge clk);
		// Idle bus shows inverted leftovers, never a stale copy
		ev_valid <= 1'h0;
		ev_kind <= ~k;
		ev_source <= ~src;
		ev_group <= ~grp;
		ev_share <= ~sh;
		ev_data <= ~d;
		#1;
	endtask
endmodule

// >>> verification/rsg_rail_sequencer_assertions.sv
/*
 Port-level concurrent checks for the rail sequencer top.
 Assumes it is bound into rsg_rail_sequencer; one clock, sync active-high reset.
*/
`timescale 1ns/10ps
module rsg_rail_sequencer_assertions #(
	parameter logic [127:0] IDENT_VALUE = 128'h0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic rsp_valid,
	input wire logic rsp_ok,
	input wire logic [4:0] rsp_count,
	input wire logic [127:0] rsp_data,
	input wire logic ev_valid,
	input wire logic [2:0] ev_kind,
	input wire logic [15:0] ev_data,
	input wire logic rail_on,
	input wire logic rail_waiting,
	input wire logic vout_update,
	input wire logic [15:0] vout_value,
	input wire logic oper_update,
	input wire logic [7:0] oper_value,
	input wire logic fail_taken
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_ident_rd;
		cmd_valid && !cmd_write && cmd_code == 8'hE4;
	endsequence
	sequence s_ident_wr;
		cmd_valid && cmd_write && cmd_code == 8'hE4;
	endsequence
	// Pulse must trace back to an event of that kind one cycle before
	property p_cause(logic upd, logic [2:0] k);
		upd |-> $past(ev_valid) && $past(ev_kind) == k;
	endproperty
	AST_RSP_NEXT: assert property (cmd_valid |=> rsp_valid)
		else $error("command without answer");
	AST_RSP_ONLY: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without command");
	AST_IDENT_READ: assert property (s_ident_rd |=> rsp_ok && rsp_count == 5'h10 && rsp_data == IDENT_VALUE)
		else $error("identifier read wrong");
	AST_IDENT_RO: assert property (s_ident_wr |=> !rsp_ok && rsp_count == 5'h00)
		else $error("identifier write accepted");
	AST_ORDER_ZERO: assert property (rsp_valid && rsp_count == 5'h02 |-> (rsp_data & ~128'h9F9F) == 128'h0)
		else $error("order word spare bits set");
	AST_GROUP_ZERO: assert property (rsp_valid && rsp_count == 5'h04 |-> (rsp_data & ~128'h3F3F3F) == 128'h0)
		else $error("group block spare bits set");
	AST_ON_AFTER_WAIT: assert property ($rose(rail_on) |-> $past(rail_waiting))
		else $error("rail on without waiting step");
	AST_WAIT_OFF: assert property (rail_waiting |-> !rail_on)
		else $error("rail on while waiting");
	AST_VOUT_CAUSE: assert property (vout_update |-> $past(ev_valid && ev_kind == 3'h3) && vout_value == $past(ev_data))
		else $error("vout update without matching event");
	AST_OPER_CAUSE: assert property (oper_update |-> $past(ev_valid && ev_kind == 3'h4) && oper_value == $past(ev_data[7:0]))
		else $error("operation update without matching event");
	AST_FAIL_CAUSE: assert property (p_cause(fail_taken, 3'h5))
		else $error("fail taken without fail event");
endmodule

// >>> verification/tb_rsg_rail_sequencer.sv
/*
 Self-checking bench: command reads and writes, peer events on the rail.
 Assumes the peer model owns the event bus; checker bound at the foot.
*/
`timescale 1ns/10ps
module tb_rsg_rail_sequencer;
	// Arbitrary identifier text
	localparam logic [127:0] IDENT = 128'h4142434445464748494A4B4C4D4E4F50;
	logic clk, sys_rst, cmd_valid, cmd_write, enable_request, current_share_setup;
	logic rsp_valid, rsp_ok, rail_on, rail_waiting, preceding_seen, vout_update, oper_update, fail_taken;
	logic ev_valid, ev_share;
	logic [2:0] ev_kind;
	logic [4:0] cmd_count, rsp_count, ev_source, ev_group;
	logic [7:0] cmd_code, oper_value;
	logic [15:0] off_delay, ev_data, vout_value;
	logic [31:0] cmd_wdata;
	logic [127:0] rsp_data;
	int err_total, checked;
	rsg_rail_sequencer #(.IDENT_VALUE(IDENT)) uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_count(cmd_count), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_count(rsp_count), .rsp_data(rsp_data),
		.enable_request(enable_request), .current_share_setup(current_share_setup), .off_delay(off_delay),
		.ev_valid(ev_valid), .ev_kind(ev_kind), .ev_source(ev_source), .ev_group(ev_group),
		.ev_share(ev_share), .ev_data(ev_data), .rail_on(rail_on), .rail_waiting(rail_waiting),
		.preceding_seen(preceding_seen), .vout_update(vout_update), .vout_value(vout_value),
		.oper_update(oper_update), .oper_value(oper_value), .fail_taken(fail_taken));
	rsg_peer_model peer (.clk(clk), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_source(ev_source),
		.ev_group(ev_group), .ev_share(ev_share), .ev_data(ev_data));
	task chk(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cmd(input logic w, input logic [7:0] c, input logic [4:0] n, input logic [31:0] d,
		input logic ok, input logic [4:0] cnt, input logic [127:0] dat);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd_write <= w;
		cmd_code <= c;
		cmd_count <= n;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_valid <= 1'h0;
		#1;
		chk(rsp_valid, 1'h1);
		chk(rsp_ok, ok);
		chk(rsp_count, cnt);
		chk(rsp_data, dat);
	endtask
	task ticks(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Shutdown locks the rail off until enable toggles
	task restart;
		@(posedge clk) enable_request <= 1'h0;
		ticks(8);
		@(posedge clk) enable_request <= 1'h1;
		ticks(4);
		chk(rail_on, 1'h1);
	endtask
	task wrap_up;
		$display("Mismatches %0d, comparisons %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		wrap_up;
	end
	initial begin
		{sys_rst, cmd_valid, cmd_write, enable_request, current_share_setup} = 5'h10;
		{cmd_code, cmd_count, cmd_wdata} = 45'h0;
		off_delay = 16'h3;
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		cmd(1'h0, 8'hE0, 5'h0, 32'h0, 1'h1, 5'h02, 128'h0);
		cmd(1'h0, 8'hE2, 5'h0, 32'h0, 1'h1, 5'h04, 128'h0);
		cmd(1'h1, 8'hE0, 5'h02, 32'hFFFF, 1'h1, 5'h02, 128'h0);
		cmd(1'h0, 8'hE0, 5'h0, 32'h0, 1'h1, 5'h02, 128'h9F9F);
		cmd(1'h1, 8'hE2, 5'h04, 32'hFFFFFFFF, 1'h1, 5'h04, 128'h0);
		cmd(1'h0, 8'hE2, 5'h0, 32'h0, 1'h1, 5'h04, 128'h3F3F3F);
		cmd(1'h0, 8'hE4, 5'h0, 32'h0, 1'h1, 5'h10, IDENT);
		cmd(1'h1, 8'hE4, 5'h10, 32'h0, 1'h0, 5'h00, 128'h0);
		cmd(1'h1, 8'hE0, 5'h04, 32'h0, 1'h0, 5'h00, 128'h0);
		cmd(1'h1, 8'hE1, 5'h02, 32'h0, 1'h0, 5'h00, 128'h0);
		cmd(1'h0, 8'hE0, 5'h0, 32'h0, 1'h1, 5'h02, 128'h9F9F);
		cmd(1'h1, 8'hE0, 5'h02, 32'h8305, 1'h1, 5'h02, 128'h0);
		@(posedge clk) enable_request <= 1'h1;
		ticks(3);
		chk(rail_waiting, 1'h1);
		peer.send(3'h1, 5'h04, 5'h0, 1'h0, 16'h0);
		ticks(2);
		chk(rail_on, 1'h0);
		peer.send(3'h1, 5'h03, 5'h0, 1'h0, 16'h0);
		chk(preceding_seen, 1'h1);
		ticks(1);
		chk(rail_on, 1'h1);
		cmd(1'h1, 8'hE0, 5'h02, 32'h0005, 1'h1, 5'h02, 128'h0);
		peer.send(3'h2, 5'h05, 5'h0, 1'h0, 16'h0);
		ticks(6);
		chk(rail_on, 1'h1);
		cmd(1'h1, 8'hE0, 5'h02, 32'h0085, 1'h1, 5'h02, 128'h0);
		peer.send(3'h2, 5'h06, 5'h0, 1'h0, 16'h0);
		ticks(6);
		chk(rail_on, 1'h1);
		peer.send(3'h2, 5'h05, 5'h0, 1'h0, 16'h0);
		ticks(3);
		chk(rail_on, 1'h1);
		ticks(1);
		chk(rail_on, 1'h0);
		restart;
		// Group block: output-voltage group 9, operation group 10, sequenced power-fail group 7
		cmd(1'h1, 8'hE2, 5'h04, 32'h00292A07, 1'h1, 5'h04, 128'h0);
		peer.send(3'h3, 5'h0, 5'h09, 1'h0, 16'h1234);
		chk(vout_value, 16'h1234);
		chk(vout_update, 1'h1);
		peer.send(3'h3, 5'h0, 5'h08, 1'h0, 16'h5555);
		chk(vout_update, 1'h0);
		peer.send(3'h4, 5'h0, 5'h0A, 1'h0, 16'h00A5);
		chk(oper_value, 8'hA5);
		chk(oper_update, 1'h1);
		cmd(1'h1, 8'hE2, 5'h04, 32'h00090A07, 1'h1, 5'h04, 128'h0);
		peer.send(3'h3, 5'h0, 5'h09, 1'h0, 16'h1234);
		chk(vout_update, 1'h0);
		peer.send(3'h4, 5'h0, 5'h0A, 1'h0, 16'h00A5);
		chk(oper_update, 1'h0);
		peer.send(3'h5, 5'h0, 5'h06, 1'h0, 16'h0);
		chk(fail_taken, 1'h0);
		peer.send(3'h5, 5'h0, 5'h07, 1'h0, 16'h0);
		chk(rail_on, 1'h1);
		chk(fail_taken, 1'h1);
		ticks(6);
		chk(rail_on, 1'h0);
		restart;
		cmd(1'h1, 8'hE2, 5'h04, 32'h00090A27, 1'h1, 5'h04, 128'h0);
		peer.send(3'h5, 5'h0, 5'h07, 1'h0, 16'h0);
		chk(rail_on, 1'h0);
		restart;
		@(posedge clk) current_share_setup <= 1'h1;
		peer.send(3'h5, 5'h0, 5'h14, 1'h1, 16'h0);
		chk(rail_on, 1'h0);
		chk(fail_taken, 1'h1);
		wrap_up;
	end
endmodule
bind rsg_rail_sequencer rsg_rail_sequencer_assertions #(.IDENT_VALUE(IDENT_VALUE)) u_chk (.clk(clk),
	.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
	.rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_count(rsp_count), .rsp_data(rsp_data),
	.ev_valid(ev_valid), .ev_kind(ev_kind), .ev_data(ev_data), .rail_on(rail_on),
	.rail_waiting(rail_waiting), .vout_update(vout_update), .vout_value(vout_value),
	.oper_update(oper_update), .oper_value(oper_value), .fail_taken(fail_taken));
